// ---- hw/fbmc_host.sv ----
// Host-side controller driving the flash through its bus pins.
// Assumes pin inputs are synchronous to sys_clk; the bench resolves dq.
`timescale 1ns/1ps
module fbmc_host
#(
   parameter int RESET_PULSE_CYC = fbmc_pkg::RESET_PULSE_CYC
)
(
   input  wire logic                       sys_clk,
   input  wire logic                       reset,
   input  wire logic                       req_valid,
   output      logic                       req_ready,
   input  wire fbmc_pkg::fbmc_req_t        req,
   input  wire logic                       byte_mode,
   input  wire logic                       accel_req,
   input  wire logic                       flash_reset_req,
   output      logic                       rsp_valid,
   output      logic [fbmc_pkg::DATA_W-1:0] rsp_data,
   output      fbmc_pkg::fbmc_pins_t       pins,
   output      logic                       width_select,
   output      logic                       protect_accel_pin,
   output      logic                       accel_level_en,
   input  wire logic                       ready_busy_n,
   input  wire logic [fbmc_pkg::DATA_W-1:0] dq_in,
   output      logic [fbmc_pkg::DATA_W-1:0] dq_out,
   output      logic [fbmc_pkg::DATA_W-1:0] dq_oe
);

   typedef enum logic [3:0] {
      FBMC_RST_HOLD,
      FBMC_RST_WAIT,
      FBMC_IDLE,
      FBMC_RD_ACCESS,
      FBMC_WR_PULSE,
      FBMC_WR_RECOVER,
      FBMC_DONE
   } fbmc_state_t;

   initial
   begin
      if (RESET_PULSE_CYC < 1 || RESET_PULSE_CYC > 255)
         $error("RESET_PULSE_CYC out of range");
   end

   fbmc_state_t                     state_r;
   logic [fbmc_pkg::CNT_W-1:0]      cnt_r;
   logic [1:0]                      step_r;
   logic [1:0]                      steps_r;
   fbmc_pkg::fbmc_req_t             cur_r;
   logic                            selected_r;
   logic                            byte_r;
   logic                            accel_r;
   logic [fbmc_pkg::ADDR_W-1:0]     wr_addr;
   logic [fbmc_pkg::DATA_W-1:0]     wr_data;

   function automatic logic [fbmc_pkg::CNT_W-1:0] cyc(input int n);
      return fbmc_pkg::CNT_W'(n - 1);
   endfunction : cyc

   // Cycle address/data of the current step of a write sequence
   always_comb
   begin
      wr_addr = cur_r.addr;
      wr_data = cur_r.data;
      if (cur_r.op == fbmc_pkg::FBMC_OP_PROGRAM && step_r < steps_r)
      begin
         // Shortened mode skips both unlock cycles
         if (steps_r == 2'd1)
            wr_data = fbmc_pkg::PROG_SETUP;
         else if (step_r == 2'd0)
         begin
            wr_addr = fbmc_pkg::UNLOCK_ADDR1;
            wr_data = fbmc_pkg::UNLOCK_DATA1;
         end
         else if (step_r == 2'd1)
         begin
            wr_addr = fbmc_pkg::UNLOCK_ADDR2;
            wr_data = fbmc_pkg::UNLOCK_DATA2;
         end
         else
         begin
            wr_addr = fbmc_pkg::UNLOCK_ADDR1;
            wr_data = fbmc_pkg::PROG_SETUP;
         end
      end
   end

   assign req_ready = (state_r == FBMC_IDLE) && !flash_reset_req;

   // Sequencer
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state_r    <= FBMC_RST_HOLD;
         cnt_r      <= '0;
         step_r     <= 2'd0;
         steps_r    <= 2'd0;
         cur_r      <= '0;
         selected_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            FBMC_RST_HOLD:
            begin
               // Pulse held at least the minimum width
               if (cnt_r >= cyc(RESET_PULSE_CYC) && !flash_reset_req)
               begin
                  state_r <= FBMC_RST_WAIT;
                  cnt_r   <= '0;
               end
               else if (cnt_r < cyc(RESET_PULSE_CYC))
                  cnt_r <= cnt_r + 1'b1;
            end
            FBMC_RST_WAIT:
            begin
               // Wait for reset-high-to-read and device ready
               if (cnt_r >= cyc(fbmc_pkg::RH_READ_CYC) && ready_busy_n)
               begin
                  state_r    <= FBMC_IDLE;
                  selected_r <= 1'b0;
               end
               else if (cnt_r < cyc(fbmc_pkg::RH_READ_CYC))
                  cnt_r <= cnt_r + 1'b1;
            end
            FBMC_IDLE:
            begin
               cnt_r  <= '0;
               step_r <= 2'd0;
               // Reset only between requests, so no sequence is cut
               if (flash_reset_req)
               begin
                  state_r <= FBMC_RST_HOLD;
               end
               else if (req_valid)
               begin
                  cur_r <= req;
                  if (req.op == fbmc_pkg::FBMC_OP_READ)
                     state_r <= FBMC_RD_ACCESS;
                  else
                     state_r <= FBMC_WR_PULSE;
                  // Index of the last write cycle of the sequence
                  if (req.op != fbmc_pkg::FBMC_OP_PROGRAM)
                     steps_r <= 2'd0;
                  else if (accel_r)
                     steps_r <= 2'd1;
                  else
                     steps_r <= 2'd3;
               end
            end
            FBMC_RD_ACCESS:
            begin
               // Leaving standby needs the select access time
               if (cnt_r >= cyc(selected_r ? fbmc_pkg::ADDR_ACCESS_CYC
                                           : fbmc_pkg::SEL_ACCESS_CYC))
               begin
                  state_r    <= FBMC_DONE;
                  selected_r <= 1'b1;
               end
               else
                  cnt_r <= cnt_r + 1'b1;
            end
            FBMC_WR_PULSE:
            begin
               if (cnt_r >= cyc(fbmc_pkg::WR_PULSE_CYC))
               begin
                  state_r <= FBMC_WR_RECOVER;
                  cnt_r   <= '0;
               end
               else
                  cnt_r <= cnt_r + 1'b1;
            end
            FBMC_WR_RECOVER:
            begin
               selected_r <= 1'b0;
               if (cnt_r >= cyc(fbmc_pkg::WR_RECOVER_CYC))
               begin
                  cnt_r <= '0;
                  if (step_r == steps_r)
                     state_r <= FBMC_DONE;
                  else
                  begin
                     step_r  <= step_r + 2'd1;
                     state_r <= FBMC_WR_PULSE;
                  end
               end
               else
                  cnt_r <= cnt_r + 1'b1;
            end
            default:
               state_r <= FBMC_IDLE;
         endcase
      end
   end

   // Width and accelerate latched only between accesses
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         byte_r  <= 1'b0;
         accel_r <= 1'b0;
      end
      else if (state_r == FBMC_IDLE && !req_valid)
      begin
         byte_r  <= byte_mode;
         accel_r <= accel_req;
      end
   end

   // Read data capture
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (state_r == FBMC_RD_ACCESS && state_r != FBMC_DONE &&
             cnt_r >= cyc(selected_r ? fbmc_pkg::ADDR_ACCESS_CYC
                                     : fbmc_pkg::SEL_ACCESS_CYC))
         begin
            rsp_valid <= 1'b1;
            if (byte_r)
               rsp_data <= {8'h00, dq_in[7:0]};
            else
               rsp_data <= dq_in;
         end
      end
   end

   // Bus pins, registered
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         pins   <= '{select_n: 1'b1, gate_n: 1'b1, strobe_n: 1'b1,
                     reset_n: 1'b0, addr: '0};
         dq_out <= '0;
         dq_oe  <= '0;
      end
      else
      begin
         pins.reset_n  <= !(state_r == FBMC_RST_HOLD);
         pins.select_n <= 1'b1;
         pins.gate_n   <= 1'b1;
         pins.strobe_n <= 1'b1;
         dq_out        <= '0;
         dq_oe         <= '0;
         if (state_r == FBMC_RD_ACCESS)
         begin
            pins.select_n <= 1'b0;
            pins.gate_n   <= 1'b0;
            pins.addr     <= cur_r.addr >> 1;
            if (byte_r)
            begin
               dq_out[fbmc_pkg::DQ_LSB_ADDR] <= cur_r.addr[0];
               dq_oe[fbmc_pkg::DQ_LSB_ADDR]  <= 1'b1;
            end
         end
         else if (state_r == FBMC_WR_PULSE)
         begin
            pins.select_n <= 1'b0;
            pins.strobe_n <= 1'b0;
            pins.addr     <= wr_addr >> 1;
            if (byte_r)
            begin
               dq_out <= {wr_addr[0], 7'h00, wr_data[7:0]};
               dq_oe  <= 16'h80FF;
            end
            else
            begin
               dq_out <= wr_data;
               dq_oe  <= 16'hFFFF;
            end
         end
      end
   end

   // Pin is always driven to a level, never left floating
   assign protect_accel_pin = 1'b1;
   // Level only while a program sequence is on the pins
   assign accel_level_en    = accel_r &&
                              cur_r.op == fbmc_pkg::FBMC_OP_PROGRAM &&
                              (state_r == FBMC_WR_PULSE ||
                               state_r == FBMC_WR_RECOVER);
   assign width_select      = !byte_r;

endmodule : fbmc_host

// ---- pkg/fbmc_pkg.sv ----
// Constants and carrier types for the flash bus mode controller (host end).
// Assumes a 40 MHz sys_clk; flash pins are sampled synchronously.
// Overview of operation
// - Host reads with select, gate low, strobe high
// - Host writes with strobe, select low, gate high
// - Shortened program mode uses two write cycles
// - Host uses accelerate only for two-cycle program
// - Host never leaves protect/accelerate pin floating
// - Host resets the flash only between requests, never mid-sequence
// - No read until reset-high-to-read elapsed
package fbmc_pkg;

   localparam int CLK_PERIOD_PS = 25000;
   localparam int ADDR_W        = 21;
   localparam int DATA_W        = 16;
   localparam int DQ_LSB_ADDR   = 15;

   // Times in ns, counts derived from the clock period
   localparam int RESET_PULSE_MIN_NS     = 500;
   localparam int RESET_HIGH_TO_READ_NS  = 50;
   localparam int SELECT_ACCESS_TIME_NS  = 70;
   localparam int ADDRESS_ACCESS_TIME_NS = 70;
   localparam int WRITE_PULSE_NS         = 35;
   localparam int WRITE_RECOVER_NS       = 30;

   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : ns_to_cyc

   localparam int RESET_PULSE_CYC = ns_to_cyc(RESET_PULSE_MIN_NS);
   localparam int RH_READ_CYC     = ns_to_cyc(RESET_HIGH_TO_READ_NS);
   localparam int SEL_ACCESS_CYC  = ns_to_cyc(SELECT_ACCESS_TIME_NS);
   localparam int ADDR_ACCESS_CYC = ns_to_cyc(ADDRESS_ACCESS_TIME_NS);
   localparam int WR_PULSE_CYC    = ns_to_cyc(WRITE_PULSE_NS);
   localparam int WR_RECOVER_CYC  = ns_to_cyc(WRITE_RECOVER_NS);
   localparam int CNT_W           = 8;

   // Unlock cycle addresses and data for the standard program sequence
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 21'h000555;
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 21'h0002AA;
   localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00AA;
   localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
   localparam logic [DATA_W-1:0] PROG_SETUP   = 16'h00A0;

   typedef enum logic [1:0] {
      FBMC_OP_READ,
      FBMC_OP_WRITE,
      FBMC_OP_PROGRAM
   } fbmc_op_t;

   typedef struct packed {
      fbmc_op_t          op;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fbmc_req_t;

   typedef struct packed {
      logic              select_n;
      logic              gate_n;
      logic              strobe_n;
      logic              reset_n;
      logic [ADDR_W-1:0] addr;
   } fbmc_pins_t;

endpackage : fbmc_pkg

// ---- verif/fbmc_chk.sv ----
// Pin sequencing checks for the flash host controller.
// Assumes binding into fbmc_host; sees its ports only.
`timescale 1ns/1ps
module fbmc_chk
#(
   parameter int RESET_PULSE_CYC = 2
)
(
   input wire logic                        sys_clk,
   input wire logic                        reset,
   input wire logic                        rsp_valid,
   input wire fbmc_pkg::fbmc_pins_t        pins,
   input wire logic                        width_select,
   input wire logic                        protect_accel_pin,
   input wire logic                        accel_level_en,
   input wire logic [fbmc_pkg::DATA_W-1:0] dq_oe
);
   logic       rd_on;
   logic [7:0] low_cnt_r;
   assign rd_on = !pins.select_n && !pins.gate_n;
   // Saturates so a stuck reset cannot wrap into a short pulse
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
         low_cnt_r <= 8'h00;
      else if (pins.reset_n)
         low_cnt_r <= 8'h00;
      else if (low_cnt_r != 8'hFF)
         low_cnt_r <= low_cnt_r + 8'h01;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence s_rd_start;
      $rose(rd_on);
   endsequence
   sequence s_rd_held;
      rd_on[*3];
   endsequence
   read_ctrl_a: assert property (rd_on |-> pins.strobe_n)
      else $error("read with write strobe low");
   write_ctrl_a: assert property (
      !pins.strobe_n |-> !pins.select_n && pins.gate_n)
      else $error("write strobe outside a write cycle");
   pin_driven_a: assert property (protect_accel_pin)
      else $error("protect pin not driven high");
   reset_width_a: assert property (
      $rose(pins.reset_n) |-> low_cnt_r >= RESET_PULSE_CYC)
      else $error("flash reset pulse too short");
   reset_read_a: assert property ($rose(pins.reset_n) |-> (!rd_on)[*2])
      else $error("read too soon after flash reset");
   read_hold_a: assert property (s_rd_start |-> s_rd_held)
      else $error("read released before access time");
   read_answer_a: assert property (s_rd_start |-> ##[2:6] rsp_valid)
      else $error("read answer missing");
   byte_pins_a: assert property (
      rd_on && !width_select |-> dq_oe[15] && dq_oe[14:8] == 7'h00)
      else $error("byte read pins wrong");
   write_width_a: assert property (
      !pins.strobe_n && width_select |-> dq_oe == 16'hFFFF)
      else $error("word write not fully driven");
   accel_only_a: assert property (accel_level_en |-> !rd_on)
      else $error("accelerate level applied during a read");
endmodule : fbmc_chk

bind fbmc_host fbmc_chk #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) u_chk
   (.sys_clk(sys_clk), .reset(reset), .rsp_valid(rsp_valid), .pins(pins),
    .width_select(width_select), .protect_accel_pin(protect_accel_pin),
    .accel_level_en(accel_level_en),
    .dq_oe(dq_oe));

// ---- verif/fbmc_flash_model.sv ----
// Behavioural flash device behind the host controller pins.
// Assumes pins move on sys_clk edges; the bench resolves the dq wire.
`timescale 1ns/1ps
module fbmc_flash_model
#(
   parameter logic [7:0] QUERY_CODE = 8'h5A, // Arbitrary value
   parameter int         BUSY_CYC   = 6
)
(
   input  wire logic                        sys_clk,
   input  wire fbmc_pkg::fbmc_pins_t        pins,
   input  wire logic                        width_select,
   input  wire logic                        acc_hi,
   input  wire logic [fbmc_pkg::DATA_W-1:0] dq,
   output      logic [fbmc_pkg::DATA_W-1:0] dq_val,
   output      logic                        ready_busy_n
);
   logic [7:0]  mem [int];
   logic [15:0] last = 16'h0000;
   logic [15:0] wd;
   logic        lat, prog, query;
   int          seq, busy, ba, wa;
   function automatic logic [7:0] rd(input int a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction : rd
   assign ba = width_select ? int'({pins.addr, 1'b0}) : int'({pins.addr, dq[15]});
   assign ready_busy_n = (busy == 0);
   // Released lines toggle so a stale value never reads as good
   always @*
   begin
      dq_val = ~last;
      if (!pins.select_n && !pins.gate_n && pins.reset_n)
         dq_val = width_select ? (query ? {8'h00, QUERY_CODE}
            : {rd(ba + 1), rd(ba)}) : {~last[15:8], query ? QUERY_CODE : rd(ba)};
   end
   always @(posedge sys_clk)
   begin
      last <= dq_val;
      if (busy > 0)
         busy <= busy - 1;
      if (!pins.reset_n)
      begin
         seq   <= 0;
         prog  <= 1'b0;
         query <= 1'b0;
         lat   <= 1'b0;
         busy  <= (busy > 0) ? BUSY_CYC : 0;
      end
      else if (!pins.strobe_n && !pins.select_n && pins.gate_n)
      begin
         lat <= 1'b1;
         wa  <= ba;
         wd  <= dq;
      end
      else if (lat)
      begin
         lat <= 1'b0;
         if (prog)
         begin
            mem[wa] = rd(wa) & wd[7:0];
            if (width_select)
               mem[wa + 1] = rd(wa + 1) & wd[15:8];
            prog <= 1'b0;
            busy <= BUSY_CYC;
         end
         else if (wd[7:0] == 8'hF0)
         begin
            seq   <= 0;
            query <= 1'b0;
         end
         else if (acc_hi && wd[7:0] == 8'hA0)
            prog <= 1'b1;
         else if (seq == 2)
         begin
            prog  <= (wd[7:0] == 8'hA0);
            query <= (wd[7:0] == 8'h90);
            seq   <= 0;
         end
         else
            seq <= (wd[7:0] == ((seq == 0) ? 8'hAA : 8'h55)) ? seq + 1 : 0;
      end
   end
endmodule : fbmc_flash_model

// ---- verif/test_flash_bus_mode_control.sv ----
// Self-checking bench: host controller against a behavioural flash.
// Assumes a shortened flash reset pulse; the dq wire is resolved here.
`timescale 1ns/1ps
module test_flash_bus_mode_control;
   localparam logic [7:0] QCODE = 8'h3C; // Arbitrary value
   logic                 sys_clk = 1'b0;
   logic                 reset = 1'b1;
   logic                 req_valid = 1'b0;
   logic                 byte_mode = 1'b0;
   logic                 accel_req = 1'b0;
   logic                 flash_reset_req = 1'b0;
   fbmc_pkg::fbmc_req_t  req = '0;
   fbmc_pkg::fbmc_pins_t pins;
   logic                 req_ready, rsp_valid, width_select, ready_busy_n;
   logic                 protect_accel_pin, accel_level_en;
   logic [15:0]          rsp_data, dq_in, dq_out, dq_oe, dq_val, d;
   logic                 strb_q = 1'b1;
   logic [7:0]           ref_mem [int];
   logic [15:0]          qcmd [3] = '{16'h00AA, 16'h0055, 16'h0090};
   int                   seed = 32'h1695A068;
   int                   err_total = 0;
   int                   tests_run = 0;
   int                   n_strobe = 0;
   int                   a;
   bit                   in_query = 1'b0;

   fbmc_host #(.RESET_PULSE_CYC(4)) DUT (.sys_clk(sys_clk), .reset(reset),
      .req_valid(req_valid), .req_ready(req_ready), .req(req),
      .byte_mode(byte_mode), .accel_req(accel_req),
      .flash_reset_req(flash_reset_req), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .pins(pins), .width_select(width_select),
      .protect_accel_pin(protect_accel_pin), .accel_level_en(accel_level_en),
      .ready_busy_n(ready_busy_n), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe));
   fbmc_flash_model #(.QUERY_CODE(QCODE)) u_flash (.sys_clk(sys_clk),
      .pins(pins), .width_select(width_select),
      .acc_hi(accel_level_en && protect_accel_pin), .dq(dq_in),
      .dq_val(dq_val), .ready_busy_n(ready_busy_n));

   assign dq_in = (dq_out & dq_oe) | (dq_val & ~dq_oe);
   initial forever #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      strb_q <= pins.strobe_n;
      if (strb_q && !pins.strobe_n)
         n_strobe++;
   end

   function automatic logic [7:0] ref_rd(input int a);
      return ref_mem.exists(a) ? ref_mem[a] : 8'hFF;
   endfunction : ref_rd

   task automatic print_verdict;
      if (err_total == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Holds the request until the edge that takes it, then waits for idle
   task automatic issue(input fbmc_pkg::fbmc_op_t op, input int a,
                        input logic [15:0] d);
      int          n;
      int          s;
      logic [15:0] e;
      n = 0;
      s = n_strobe;
      e = in_query ? {8'h00, QCODE} : byte_mode ? {8'h00, ref_rd(a)}
          : {ref_rd(a + 1), ref_rd(a)};
      req_valid <= 1'b1;
      req       <= '{op, a[20:0], d};
      do
         @(posedge sys_clk);
      while (req_ready !== 1'b1 && ++n < 400);
      req_valid <= 1'b0;
      n = 0;
      if (op == fbmc_pkg::FBMC_OP_READ)
      begin
         do
            @(posedge sys_clk);
         while (rsp_valid !== 1'b1 && ++n < 50);
         chk({rsp_valid, rsp_data}, {1'b1, e});
      end
      do
         @(posedge sys_clk);
      while (req_ready !== 1'b1 && ++n < 400);
      if (op == fbmc_pkg::FBMC_OP_PROGRAM)
      begin
         ref_mem[a] = ref_rd(a) & d[7:0];
         if (!byte_mode)
            ref_mem[a + 1] = ref_rd(a + 1) & d[15:8];
         chk(17'(n_strobe - s), accel_req ? 17'h2 : 17'h4);
      end
   endtask : issue

   initial
   begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      for (int m = 0; m < 4; m++)
      begin
         byte_mode <= m[0];
         accel_req <= m[1];
         @(posedge sys_clk);
         repeat (5)
         begin
            a = $random(seed) & (m[0] ? 32'h3F : 32'h3E);
            d = 16'($random(seed)) & (m[0] ? 16'h00FF : 16'hFFFF);
            issue(fbmc_pkg::FBMC_OP_READ, a, 16'h0000);
            issue(fbmc_pkg::FBMC_OP_PROGRAM, a, d);
            issue(fbmc_pkg::FBMC_OP_READ, a, 16'h0000);
         end
      end
      byte_mode <= 1'b0;
      accel_req <= 1'b0;
      @(posedge sys_clk);
      for (int j = 0; j < 2; j++)
      begin
         foreach (qcmd[i])
            issue(fbmc_pkg::FBMC_OP_WRITE, 0, qcmd[i]);
         in_query = 1'b1;
         issue(fbmc_pkg::FBMC_OP_READ, 4, 16'h0000);
         if (j == 0)
            issue(fbmc_pkg::FBMC_OP_WRITE, 0, 16'h00F0);
         else
         begin
            flash_reset_req <= 1'b1;
            @(posedge sys_clk);
            flash_reset_req <= 1'b0;
         end
         in_query = 1'b0;
         issue(fbmc_pkg::FBMC_OP_READ, 4, 16'h0000);
      end
      print_verdict();
   end

   // Run needs under a thousand cycles; this bound cuts a hang
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      print_verdict();
   end
endmodule : test_flash_bus_mode_control
